/* rtl/ssm_pkg.sv */
// Contract
// - Master and synchronous bits both set make the port a clock master.
// - Port enable bit turns the two pins into clock and data lines.
// - Half-duplex: sending blocks reception, receiving blocks sending.
// - The device generates and drives the shift clock itself.
// - Clock polarity bit sets the clock line idle level.
// - Data polarity bit sets the data line idle level.
// - Data is sampled where the clock returns to its idle level.
// - Shift register reloads only after the last bit, at once if data waits.
// - Transmit flag sets regardless of enable; only buffer writes clear it.
// - Transmit interrupt request is gated by its enable bit.
// - Read-only shift-register-empty bit, polled, no interrupt from it; the code latches each word end as event bit 1, which can raise irq.
// - The shift register is not reachable by software.
`default_nettype none
package ssm_pkg;
	// ****************************************
	// Register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_TXSC = 8'h00;
	localparam logic [7:0] OFS_RXSC = 8'h04;
	localparam logic [7:0] OFS_BAUDC = 8'h08;
	localparam logic [7:0] OFS_DIVL = 8'h0c;
	localparam logic [7:0] OFS_DIVH = 8'h10;
	localparam logic [7:0] OFS_HOLD = 8'h14;
	localparam logic [7:0] OFS_PFLAG = 8'h18;
	localparam logic [7:0] OFS_PEN = 8'h1c;
	localparam logic [7:0] OFS_ICTL = 8'h20;
	localparam logic [7:0] OFS_EVT = 8'h24;
	localparam logic [7:0] OFS_EMASK = 8'h28;
	localparam logic [7:0] OFS_LINE = 8'h2c;
	// ****************************************
	// Field positions and write masks
	// ****************************************
	localparam int TXSC_MASTER = 7;
	localparam int TXSC_NINE = 6;
	localparam int TXSC_TRANSMIT_ENABLE = 5;
	localparam int TXSC_SYNC = 4;
	localparam int TXSC_EMPTY = 1;
	localparam int TXSC_NINTH = 0;
	localparam int RXSC_SERIAL_PORT_ENABLE = 7;
	localparam int RXSC_SREN = 5;
	localparam int RXSC_CREN = 4;
	localparam int RXSC_INHIB = 1;
	localparam int BAUD_DATA_POL = 5;
	localparam int BAUD_CLK_POL = 4;
	localparam int BAUD_16 = 3;
	localparam int PFLAG_TX = 4;
	localparam int PEN_TX = 4;
	localparam int ICTL_GIE = 7;
	localparam int ICTL_PERIPHERAL_IRQ_ENABLE = 6;
	localparam logic [7:0] TXSC_WMASK = 8'hf1;
	localparam logic [7:0] RXSC_WMASK = 8'hb0;
	localparam logic [7:0] BAUDC_WMASK = 8'h38;
	localparam logic [7:0] PEN_WMASK = 8'h10;
	localparam logic [7:0] ICTL_WMASK = 8'hc0;
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [1:0] RST_EVT = 2'h0;
	// ****************************************
	// Timing and counts
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int TCY_NS = 40;
	localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] TCY_LAST = 3'(TCY_CYCLES - 1);
	localparam logic [3:0] BITS_EIGHT = 4'h8;
	localparam logic [3:0] BITS_NINE = 4'h9;
	// ****************************************
	// Transmit sequencer states
	// ****************************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_LEAD = 2'b10,
		ST_TRAIL = 2'b11
	} ssm_state_t;
endpackage : ssm_pkg
`default_nettype wire

/* rtl/ssm_brg_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Baud generator link between the sequencer and its divider
interface ssm_brg_if;
	logic run;
	logic [15:0] divisor;
	logic tick;
	modport gen (input run, input divisor, output tick);
	modport user (output run, output divisor, input tick);
endinterface : ssm_brg_if
`default_nettype wire

/* rtl/ssm_baud_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_baud_gen
	import ssm_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sequencer side
	ssm_brg_if.gen brg
);
	logic [16:0] cnt_q;
	logic tick_q;
	wire [16:0] limit;
	wire at_limit;

	// Half shift period is 2*(divisor+1) clocks
	assign limit = {brg.divisor, 1'b1};
	assign at_limit = (cnt_q == limit);
	assign brg.tick = tick_q;

	// Counter restarts whenever the sequencer stops, so phase is fresh
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= (!brg.run || at_limit) ? '0 : cnt_q + 17'h1;
			tick_q <= brg.run && at_limit;
		end
	end

	// No tick right after a restart
	a_tick_restart: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(brg.run) |-> !brg.tick [*2])
		else $error("tick too soon after start");
endmodule : ssm_baud_gen
`default_nettype wire

/* rtl/ssm_tx_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ssm_tx_top
	import ssm_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shift clock line
	input wire logic shift_clock_line_i,
	output logic shift_clock_line_o,
	output logic shift_clock_line_oe,
	// Shift data line
	input wire logic shift_data_line_i,
	output logic shift_data_line_o,
	output logic shift_data_line_oe,
	// Interrupt
	output logic irq
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] txsc_q, rxsc_q, baudc_q, divl_q, divh_q, hold_q;
	logic [7:0] pen_q, ictl_q;
	logic [1:0] evt_q, emask_q;
	logic transmit_buffer_empty_flag_q, hold_full_q;
	ssm_state_t state_q, state_d;
	logic [8:0] tsr_q, tsr_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [2:0] tcy_cnt_q, tcy_cnt_d;
	logic ck_q, dt_q, ck_oe_q, dt_oe_q, irq_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic ck_s1_q, ck_s2_q, dt_s1_q, dt_s2_q;
	wire acc_req, hold_stall, take, wr_en, mapped;
	wire wr_txsc, wr_rxsc, wr_baudc, wr_divl, wr_divh, wr_hold;
	wire wr_pen, wr_ictl, wr_evt, wr_emask;
	wire tx_ok, rx_req, start, busy, shifting, shift_register_empty, tick;
	wire lead_tick, trail_tick, load_done, word_done;
	wire clk_pol, data_pol, lines_on, tx_irq;
	wire [1:0] evt_set;
	wire [7:0] txsc_rd, rxsc_rd, pflag_rd, line_rd, rd8;
	wire [31:0] rd_data;
	ssm_brg_if brg_bus ();

	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	// ****************************************
	// APB slave
	// ****************************************
	// One wait state; holding-buffer writes wait out a transfer
	assign acc_req = psel & penable & ~pready_q;
	assign hold_stall = (state_q == ST_LOAD) & pwrite & hit(paddr, OFS_HOLD);
	assign take = acc_req & ~hold_stall;
	assign wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
	assign mapped = hit(paddr, OFS_TXSC) | hit(paddr, OFS_RXSC) |
		hit(paddr, OFS_BAUDC) | hit(paddr, OFS_DIVL) |
		hit(paddr, OFS_DIVH) | hit(paddr, OFS_HOLD) |
		hit(paddr, OFS_PFLAG) | hit(paddr, OFS_PEN) |
		hit(paddr, OFS_ICTL) | hit(paddr, OFS_EVT) |
		hit(paddr, OFS_EMASK) | hit(paddr, OFS_LINE);

	// Write strobes
	assign wr_txsc = wr_en & hit(paddr, OFS_TXSC);
	assign wr_rxsc = wr_en & hit(paddr, OFS_RXSC);
	assign wr_baudc = wr_en & hit(paddr, OFS_BAUDC);
	assign wr_divl = wr_en & hit(paddr, OFS_DIVL);
	assign wr_divh = wr_en & hit(paddr, OFS_DIVH);
	assign wr_hold = wr_en & hit(paddr, OFS_HOLD);
	assign wr_pen = wr_en & hit(paddr, OFS_PEN);
	assign wr_ictl = wr_en & hit(paddr, OFS_ICTL);
	assign wr_evt = wr_en & hit(paddr, OFS_EVT);
	assign wr_emask = wr_en & hit(paddr, OFS_EMASK);

	// Read views; the shift register has no address at all
	assign txsc_rd = txsc_q | ({7'h0, shift_register_empty} << TXSC_EMPTY);
	assign rxsc_rd = rxsc_q | ({7'h0, busy} << RXSC_INHIB);
	assign pflag_rd = {7'h0, transmit_buffer_empty_flag_q} << PFLAG_TX;
	assign line_rd = {6'h0, dt_s2_q, ck_s2_q};
	assign rd8 = hit(paddr, OFS_TXSC) ? txsc_rd :
		hit(paddr, OFS_RXSC) ? rxsc_rd :
		hit(paddr, OFS_BAUDC) ? baudc_q :
		hit(paddr, OFS_DIVL) ? divl_q :
		hit(paddr, OFS_DIVH) ? divh_q :
		hit(paddr, OFS_HOLD) ? hold_q :
		hit(paddr, OFS_PFLAG) ? pflag_rd :
		hit(paddr, OFS_PEN) ? pen_q :
		hit(paddr, OFS_ICTL) ? ictl_q :
		hit(paddr, OFS_EVT) ? {6'h0, evt_q} :
		hit(paddr, OFS_EMASK) ? {6'h0, emask_q} :
		hit(paddr, OFS_LINE) ? line_rd : 8'h00;
	assign rd_data = {24'h0, rd8};

	// Answer registered, so pready comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= '0;
		end else begin
			pready_q <= take;
			pslverr_q <= take & ~mapped;
			if (take)
				prdata_q <= mapped ? rd_data : '0;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	// Reserved and read-only bits never store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txsc_q <= RST_REG8;
			rxsc_q <= RST_REG8;
			baudc_q <= RST_REG8;
			divl_q <= RST_REG8;
			divh_q <= RST_REG8;
		end else begin
			if (wr_txsc)
				txsc_q <= pwdata[7:0] & TXSC_WMASK;
			if (wr_rxsc)
				rxsc_q <= pwdata[7:0] & RXSC_WMASK;
			if (wr_baudc)
				baudc_q <= pwdata[7:0] & BAUDC_WMASK;
			if (wr_divl)
				divl_q <= pwdata[7:0];
			if (wr_divh)
				divh_q <= pwdata[7:0];
		end
	end

	// Interrupt side registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pen_q <= RST_REG8;
			ictl_q <= RST_REG8;
			emask_q <= RST_EVT;
		end else begin
			if (wr_pen)
				pen_q <= pwdata[7:0] & PEN_WMASK;
			if (wr_ictl)
				ictl_q <= pwdata[7:0] & ICTL_WMASK;
			if (wr_emask)
				emask_q <= pwdata[1:0];
		end
	end

	// ****************************************
	// Holding buffer and transmit flag
	// ****************************************
	// A write while full overwrites the waiting word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_q <= RST_REG8;
			hold_full_q <= 1'b0;
			transmit_buffer_empty_flag_q <= 1'b0;
		end else begin
			if (wr_hold)
				hold_q <= pwdata[7:0];
			if (wr_hold)
				hold_full_q <= 1'b1;
			else if (load_done)
				hold_full_q <= 1'b0;
			if (load_done)
				transmit_buffer_empty_flag_q <= 1'b1;
			else if (wr_hold)
				transmit_buffer_empty_flag_q <= 1'b0;
		end
	end

	// ****************************************
	// Mode decode
	// ****************************************
	assign lines_on = rxsc_q[RXSC_SERIAL_PORT_ENABLE] & txsc_q[TXSC_SYNC];
	assign tx_ok = lines_on & txsc_q[TXSC_MASTER] &
		txsc_q[TXSC_TRANSMIT_ENABLE];
	assign rx_req = rxsc_q[RXSC_SREN] | rxsc_q[RXSC_CREN];
	// A pending receive blocks a new word
	assign start = hold_full_q & tx_ok & ~rx_req;
	assign busy = (state_q != ST_IDLE);
	assign shifting = (state_q == ST_LEAD) | (state_q == ST_TRAIL);
	assign shift_register_empty = ~shifting;
	assign clk_pol = baudc_q[BAUD_CLK_POL];
	assign data_pol = baudc_q[BAUD_DATA_POL];

	// Baud divider runs only across a word
	assign brg_bus.run = shifting;
	assign brg_bus.divisor = baudc_q[BAUD_16] ? {divh_q, divl_q} :
		{8'h00, divl_q};
	assign tick = brg_bus.tick;

	ssm_baud_gen u_brg (
		.pclk(pclk),
		.presetn(presetn),
		.brg(brg_bus)
	);

	// ****************************************
	// Transmit sequencer
	// ****************************************
	assign load_done = (state_q == ST_LOAD) & tx_ok & (tcy_cnt_q == TCY_LAST);
	assign lead_tick = (state_q == ST_LEAD) & tx_ok & tick;
	assign trail_tick = (state_q == ST_TRAIL) & tx_ok & tick;
	assign word_done = trail_tick & (bit_cnt_q == 4'h0);

	// Next state; losing a mode bit drops the word at once
	always_comb begin
		state_d = state_q;
		tsr_d = tsr_q;
		bit_cnt_d = bit_cnt_q;
		tcy_cnt_d = tcy_cnt_q;
		unique case (state_q)
			ST_IDLE: begin
				if (start) begin
					state_d = ST_LOAD;
					tcy_cnt_d = 3'h0;
				end
			end
			ST_LOAD: begin
				if (!tx_ok) begin
					state_d = ST_IDLE;
				end else if (load_done) begin
					state_d = ST_LEAD;
					tsr_d = {txsc_q[TXSC_NINTH], hold_q};
					bit_cnt_d = txsc_q[TXSC_NINE] ? BITS_NINE : BITS_EIGHT;
				end else begin
					tcy_cnt_d = tcy_cnt_q + 3'h1;
				end
			end
			ST_LEAD: begin
				if (!tx_ok) begin
					state_d = ST_IDLE;
				end else if (lead_tick) begin
					state_d = ST_TRAIL;
					tsr_d = {1'b0, tsr_q[8:1]};
					bit_cnt_d = bit_cnt_q - 4'h1;
				end
			end
			ST_TRAIL: begin
				if (!tx_ok) begin
					state_d = ST_IDLE;
				end else if (word_done) begin
					state_d = start ? ST_LOAD : ST_IDLE;
					tcy_cnt_d = 3'h0;
				end else if (trail_tick) begin
					state_d = ST_LEAD;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			tsr_q <= '0;
			bit_cnt_q <= 4'h0;
			tcy_cnt_q <= 3'h0;
		end else begin
			state_q <= state_d;
			tsr_q <= tsr_d;
			bit_cnt_q <= bit_cnt_d;
			tcy_cnt_q <= tcy_cnt_d;
		end
	end

	// ****************************************
	// Pin drivers
	// ****************************************
	// Data moves on the leading edge and returns to idle a cycle
	// after the word, so it never changes at the sampling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_q <= 1'b0;
			dt_q <= 1'b0;
			ck_oe_q <= 1'b0;
			dt_oe_q <= 1'b0;
		end else begin
			ck_q <= clk_pol ^ (state_d == ST_TRAIL);
			if (lead_tick)
				dt_q <= tsr_q[0];
			else if (!shifting)
				dt_q <= data_pol;
			ck_oe_q <= lines_on & txsc_q[TXSC_MASTER];
			dt_oe_q <= lines_on & (busy | ~rx_req);
		end
	end

	// Pins from outside pass two flops before use
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ck_s1_q <= 1'b0;
			ck_s2_q <= 1'b0;
			dt_s1_q <= 1'b0;
			dt_s2_q <= 1'b0;
		end else begin
			ck_s1_q <= shift_clock_line_i;
			ck_s2_q <= ck_s1_q;
			dt_s1_q <= shift_data_line_i;
			dt_s2_q <= dt_s1_q;
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	assign evt_set = {word_done, load_done};
	assign tx_irq = transmit_buffer_empty_flag_q & pen_q[PEN_TX] & ictl_q[ICTL_GIE] &
		ictl_q[ICTL_PERIPHERAL_IRQ_ENABLE];

	// Sticky events; a new event beats a same-cycle clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= RST_EVT;
			irq_q <= 1'b0;
		end else begin
			evt_q <= (evt_q & ~(wr_evt ? pwdata[1:0] : 2'h0)) | evt_set;
			irq_q <= (|(evt_q & emask_q)) | tx_irq;
		end
	end

	// Outputs
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign shift_clock_line_o = ck_q;
	assign shift_clock_line_oe = ck_oe_q;
	assign shift_data_line_o = dt_q;
	assign shift_data_line_oe = dt_oe_q;
	assign irq = irq_q;

	// ****************************************
	// Checks
	// ****************************************
	a_mode_drop: assert property (
		@(posedge pclk) disable iff (!presetn)
		busy && !tx_ok |=> state_q == ST_IDLE)
		else $error("word kept after mode loss");
	a_clock_drive: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(tx_ok) |=> ck_oe_q && shift_data_line_oe)
		else $error("lines not driven in master mode");
	a_half_duplex: assert property (
		@(posedge pclk) disable iff (!presetn)
		state_q == ST_IDLE && rx_req |=> state_q == ST_IDLE)
		else $error("transmit started while receiving");
	a_clock_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!shifting && $stable(clk_pol) |-> ck_q == clk_pol)
		else $error("clock not at idle level");
	a_data_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!shifting ##1 !shifting && $stable(data_pol) |-> dt_q == data_pol)
		else $error("data not at idle level");
	a_sample_edge: assert property (
		@(posedge pclk) disable iff (!presetn)
		trail_tick |=> $stable(dt_q) && ck_q == clk_pol)
		else $error("data moved at sampling edge");
	a_no_early_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		shifting && bit_cnt_q != 4'h0 |=> state_q != ST_LOAD)
		else $error("reload before last bit");
	a_load_tcy: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(state_q == ST_LOAD) && tx_ok ##3 tx_ok |=>
		state_q == ST_LEAD && transmit_buffer_empty_flag_q && !hold_full_q)
		else $error("transfer not one instruction cycle");
	a_flag_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		transmit_buffer_empty_flag_q && !wr_hold |=> transmit_buffer_empty_flag_q)
		else $error("transmit flag cleared without data");
	a_irq_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!pen_q[PEN_TX] && emask_q == 2'h0) [*2] |-> !irq_q)
		else $error("interrupt without enable");
	a_empty_flag: assert property (
		@(posedge pclk) disable iff (!presetn)
		load_done |=> !txsc_rd[TXSC_EMPTY] && !(|pflag_rd) == 1'b0)
		else $error("empty bit wrong after load");
	a_lsb_first: assert property (
		@(posedge pclk) disable iff (!presetn)
		lead_tick |=> dt_q == $past(tsr_q[0]) && ck_q != clk_pol)
		else $error("bit order or clock phase wrong");
endmodule : ssm_tx_top
`default_nettype wire

/* testbench/ssm_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Synchronous slave listening on the lines
// ****************************************
module ssm_slave_model (
	// Clock and line drivers
	input wire logic pclk,
	input wire logic ck_o,
	input wire logic ck_oe,
	input wire logic dt_o,
	input wire logic dt_oe,
	// Bench control
	input wire logic cpol,
	input wire logic clr,
	// Resolved pins and capture
	output logic ck_pin,
	output logic dt_pin,
	output logic [31:0] cap,
	output int cnt,
	output realtime gap
);
	logic ck_held = 1'b0;
	logic dt_held = 1'b0;
	logic last_ck = 1'b0;
	realtime t_last = 0.0;
	// Capture state starts empty
	initial begin
		cnt = 0;
		cap = '0;
		gap = 0.0;
	end
	// Released lines show the inverse of their last level, not a stale copy
	always @(posedge pclk) begin
		if (ck_oe) ck_held <= ck_o;
		if (dt_oe) dt_held <= dt_o;
	end
	assign ck_pin = ck_oe ? ck_o : ~ck_held;
	assign dt_pin = dt_oe ? dt_o : ~dt_held;
	// Sample data where the clock returns to idle
	always @(ck_pin or posedge clr) begin
		if (clr) begin
			cnt = 0;
		end else if (ck_pin !== last_ck && ck_pin === cpol) begin
			cap[cnt[4:0]] = dt_pin;
			cnt = cnt + 1;
			gap = $realtime - t_last;
			t_last = $realtime;
		end
		last_ck = ck_pin;
	end
endmodule : ssm_slave_model
`default_nettype wire

/* testbench/sync_serial_master_transmitter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_serial_master_transmitter_test import ssm_pkg::*; ;
	typedef struct {
		logic cpol, dpol, nine, ninth, b16;
		logic [7:0] divh, divl, data;
	} ssm_row_t;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, cap, r;
	logic pready, pslverr, ck_o, ck_oe, dt_o, dt_oe, irq, ck_pin, dt_pin, e;
	logic cpol = 1'b0;
	logic clr = 1'b0;
	int cnt;
	realtime gap;
	int n_mismatch = 0;
	int check_count = 0;
	// Rows: polarity, width, ninth bit, divisor, data
	ssm_row_t rows [4] = '{
		'{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'ha5},
		'{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 8'h01, 8'h3c},
		'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h02, 8'h81},
		'{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h01, 8'h00, 8'h7e}};
	// Clock
	always #5 pclk = ~pclk;
	// ****************************************
	// Design and far side
	// ****************************************
	ssm_tx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.shift_clock_line_i(ck_pin), .shift_clock_line_o(ck_o),
		.shift_clock_line_oe(ck_oe), .shift_data_line_i(dt_pin),
		.shift_data_line_o(dt_o), .shift_data_line_oe(dt_oe), .irq(irq));
	ssm_slave_model u_slave (.pclk(pclk), .ck_o(ck_o), .ck_oe(ck_oe),
		.dt_o(dt_o), .dt_oe(dt_oe), .cpol(cpol), .clr(clr), .ck_pin(ck_pin),
		.dt_pin(dt_pin), .cap(cap), .cnt(cnt), .gap(gap));
	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, s, x);
		end
	endtask : chk
	// One APB transfer; waits for pready with a bound
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n < 50, 1);
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Bounded waits for slave bits and the empty flag
	task wait_bits(input int k);
		int n;
		n = 0;
		while (cnt < k && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		chk(cnt >= k, 1);
	endtask : wait_bits
	task wait_empty();
		int k;
		k = 0;
		do begin
			rd(OFS_TXSC);
			k++;
		end while (r[TXSC_EMPTY] !== 1'b1 && k < 500);
		chk(r[TXSC_EMPTY], 1);
	endtask : wait_empty
	task chk_irq(input logic x);
		repeat (3) @(posedge pclk);
		chk(irq, x);
	endtask : chk_irq
	task start_word(input logic [7:0] d);
		clr <= 1'b1;
		@(posedge pclk);
		clr <= 1'b0;
		wr(OFS_HOLD, d);
	endtask : start_word
	// Configure, send one word, compare what the slave saw
	task run_row(input ssm_row_t w);
		int nb;
		int nn;
		logic [8:0] m;
		nb = w.nine ? 9 : 8;
		nn = w.b16 ? {w.divh, w.divl} : w.divl;
		m = w.nine ? 9'h1ff : 9'h0ff;
		cpol <= w.cpol;
		wr(OFS_TXSC, 32'h0);
		wr(OFS_DIVH, w.divh);
		wr(OFS_DIVL, w.divl);
		wr(OFS_BAUDC, {w.dpol, w.cpol, w.b16, 3'b000});
		wr(OFS_RXSC, 32'h80);
		wr(OFS_TXSC, {1'b1, w.nine, 2'b11, 3'b000, w.ninth});
		repeat (4) @(posedge pclk);
		chk({ck_oe, dt_oe}, 2'b11);
		chk({ck_pin, dt_o}, {w.cpol, w.dpol});
		start_word(w.data);
		wait_bits(1);
		rd(OFS_TXSC);
		chk(r[TXSC_EMPTY], 0);
		wait_bits(nb);
		wait_empty();
		chk(cap[8:0] & m, {w.ninth, w.data} & m);
		chk(int'(gap), 4 * (nn + 1) * CLK_PERIOD_NS);
		repeat (8) @(posedge pclk);
		chk({ck_pin, dt_o}, {w.cpol, w.dpol});
		chk(cnt, nb);
		rd(OFS_LINE);
		chk(r[1:0], {dt_pin, ck_pin});
		rd(OFS_PFLAG);
		chk(r[PFLAG_TX], 1);
		$display("test row done, %0d bits", nb);
	endtask : run_row
	task close_out();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out
	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk({irq, ck_oe, dt_oe, ck_o, dt_o}, 0);
		rd(OFS_BAUDC);
		chk(r, RST_REG8);
		rd(8'h30);
		chk(e, 1);
		chk(r, 0);
		$display("test reset done");
		foreach (rows[i]) run_row(rows[i]);
		// Fast clock for the awkward cases
		cpol <= 1'b0;
		wr(OFS_BAUDC, 32'h0);
		wr(OFS_DIVL, 32'h0);
		wr(OFS_TXSC, 32'hb0);
		start_word(8'h5a);
		wr(OFS_HOLD, 32'hc3);
		wait_bits(16);
		wait_empty();
		chk(cap[15:0], 16'hc35a);
		wr(OFS_PFLAG, 32'h0);
		rd(OFS_PFLAG);
		chk(r[PFLAG_TX], 1);
		start_word(8'h11);
		rd(OFS_PFLAG);
		chk(r[PFLAG_TX], 0);
		wait_bits(8);
		wait_empty();
		$display("test back to back done");
		// Events, mask and transmit request gating
		chk_irq(0);
		wr(OFS_EMASK, 32'h3);
		chk_irq(1);
		rd(OFS_EVT);
		chk(r, 3);
		wr(OFS_EVT, 32'h3);
		rd(OFS_EVT);
		chk(r, 0);
		chk_irq(0);
		wr(OFS_PEN, 32'h10);
		chk_irq(0);
		wr(OFS_ICTL, 32'hc0);
		chk_irq(1);
		wr(OFS_PEN, 32'h0);
		chk_irq(0);
		$display("test interrupt done");
		// Receive enabled blocks any transmit start
		wr(OFS_RXSC, 32'ha0);
		start_word(8'hff);
		repeat (200) @(posedge pclk);
		chk(cnt, 0);
		$display("test half duplex done");
		// Reset in mid-run drops lines, flag and waiting word
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({irq, ck_oe, dt_oe, ck_o, dt_o}, 0);
		rd(OFS_TXSC);
		chk(r, 32'h2);
		rd(OFS_PFLAG);
		chk(r, 0);
		$display("test mid-run reset done");
		close_out();
	end
	// Watchdog
	initial begin
		#900000;
		n_mismatch++;
		close_out();
	end
endmodule : sync_serial_master_transmitter_test
`default_nettype wire
